// ### tb/dsc_host_model.sv
// host controller model for the three-wire link
// open-drain data wire with pull-up; link clock stands high between bytes
module dsc_host_model #(
  parameter int HP = 6 // link half period in clk cycles
) (
  input  wire logic clk,
  input  wire logic twl_data_oe,
  output logic      twl_clk,
  output logic      twl_mode,
  output logic      twl_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv; // host drive, 1 means released
  // wire level: host or device pulls low, otherwise the pull-up wins
  assign twl_data_in = drv & ~twl_data_oe;
  initial begin
    twl_clk = 1'b1;
    twl_mode = 1'b0;
    drv = 1'b1;
  end
  // mode change while the link clock is high; call at a falling edge
  task automatic set_mode(input logic m);
    twl_mode = m;
    drv = 1'b1;
    repeat (HP) @(negedge clk);
  endtask
  // one byte lsb first; send 8'hff to release the wire for a read
  task automatic byte_io(input logic [7:0] w, output logic [7:0] r);
    for (int k = 0; k < 8; k++) begin
      twl_clk = 1'b0;
      drv = w[k];
      repeat (HP) @(negedge clk);
      twl_clk = 1'b1;
      repeat (HP) @(negedge clk);
      r[k] = twl_data_in;
    end
  endtask
endmodule

// ### tb/dsc_regs_top_asserts.sv
// port-level assertions for the decoder status / clock generator bank
// assumes one clock domain, reset nrst active low
module dsc_regs_top_asserts (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       twl_mode,
  input wire logic       twl_data_oe,
  input wire logic       frame_lock,
  input wire logic       lock_set_event_en,
  input wire logic       lock_clr_event_en,
  input wire logic       lock_set_event,
  input wire logic       lock_clr_event,
  input wire logic       sample_clock_oe,
  input wire logic       phase_up,
  input wire logic       phase_dn,
  input wire logic [7:0] first_divider,
  input wire logic [9:0] second_divider,
  input wire logic [5:0] third_divider
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // divider outputs only ever hold decoded legal values
  a_n1_step: assert property
    (first_divider[2:0] == 3'h0 && first_divider != 8'h00)
    else $error("first divider not a multiple of eight");
  a_n2_table: assert property
    (second_divider inside {10'h005, 10'h019, 10'h07d, 10'h271})
    else $error("second divider outside its table");
  a_n3_range: assert property
    (third_divider inside {[6'h01:6'h20]})
    else $error("third divider outside 1 to 32");
  // lock events follow the lock edges within a short bound
  a_lock_set_event: assert property
    ($rose(frame_lock) && lock_set_event_en |-> ##[1:3] lock_set_event)
    else $error("lock set event missing");
  a_lock_clr_event: assert property
    ($fell(frame_lock) && lock_clr_event_en |-> ##[1:3] lock_clr_event)
    else $error("lock clear event missing");
  // event is registered from the enable of the cycle before
  a_event_gated: assert property
    (!lock_set_event_en |=> !lock_set_event)
    else $error("set event while disabled");
  a_event_single: assert property
    (lock_clr_event |=> !lock_clr_event)
    else $error("clear event longer than a cycle");
  // device drives the data wire only inside a data phase
  a_oe_data_phase: assert property
    (!twl_mode [*5] |-> !twl_data_oe)
    else $error("data wire driven in address phase");
  // settings only move through a link write
  a_oe_by_link: assert property
    ($changed(sample_clock_oe) |-> twl_mode)
    else $error("output enable changed outside a write");
  // detector never asks for both directions at once
  a_phase_excl: assert property
    (!(phase_up && phase_dn))
    else $error("phase up and down both high");
endmodule

bind dsc_regs_top dsc_regs_top_asserts u_chk (
  .clk(clk), .nrst(nrst), .twl_mode(twl_mode), .twl_data_oe(twl_data_oe),
  .frame_lock(frame_lock), .lock_set_event_en(lock_set_event_en),
  .lock_clr_event_en(lock_clr_event_en), .lock_set_event(lock_set_event),
  .lock_clr_event(lock_clr_event), .sample_clock_oe(sample_clock_oe),
  .phase_up(phase_up), .phase_dn(phase_dn),
  .first_divider(first_divider), .second_divider(second_divider),
  .third_divider(third_divider)
);

// ### tb/tb_top.sv
// self-checking bench for dsc_regs_top over the three-wire link
// host model drives the link, bench drives decoder core and clock pins
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsc_pkg::*;
  logic       clk, nrst, lclk, lmode, ldin, loe, fs, flock, upd, rdy;
  logic       layer2, set_en, clr_en, set_ev, clr_ev, mclk, xclk, eclk;
  logic       erun, sck, sck_oe, ratio;
  logic [7:0] n1;
  logic [9:0] n2;
  logic [5:0] n3;
  int         n_fail, tests_run;
  logic       hbank, abank; // item bank outputs

  dsc_regs_top #(.PW(12)) DUT (
    .clk(clk), .nrst(nrst), .twl_clk(lclk), .twl_mode(lmode),
    .twl_data_in(ldin), .twl_data_out(), .twl_data_oe(loe),
    .frame_start(fs), .frame_lock(flock), .items_update(upd),
    .items_ready(rdy), .layer2(layer2), .lock_set_event_en(set_en),
    .lock_clr_event_en(clr_en), .lock_set_event(set_ev),
    .lock_clr_event(clr_ev), .anc_bank(abank), .hdr_bank(hbank),
    .master_clock_in(mclk), .aux_crystal_clock_in(xclk),
    .ext_sample_clock_in(eclk), .sample_clock_out(sck),
    .sample_clock_oe(sck_oe), .external_ratio_select(ratio),
    .phase_up(), .phase_dn(), .first_divider(n1), .second_divider(n2),
    .third_divider(n3));
  dsc_host_model #(.HP(6)) host (.clk(clk), .twl_data_oe(loe),
    .twl_clk(lclk), .twl_mode(lmode), .twl_data_in(ldin));

  // system clock and unrelated pin clocks, all edges off clk's rise
  always #2 clk = ~clk;
  always #8 mclk = ~mclk;
  always #12 xclk = ~xclk;
  always #16 if (erun) eclk = ~eclk;

  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // device address byte with a sub-mode, then enter the data phase
  task automatic addr_phase(input dsc_dom_t m);
    logic [7:0] r;
    host.set_mode(1'b0);
    host.byte_io({DSC_DEV_ADDR, m}, r);
    host.set_mode(1'b1);
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    logic [7:0] r;
    addr_phase(DSC_DOM_ADDR);
    host.byte_io(a, r);
    addr_phase(DSC_DOM_WRITE);
    host.byte_io(d, r);
    repeat (6) @(negedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr_phase(DSC_DOM_ADDR);
    host.byte_io(a, d);
    addr_phase(DSC_DOM_READ);
    host.byte_io(8'hff, d);
  endtask
  task automatic st_rd(output logic [7:0] d);
    addr_phase(DSC_DOM_STATUS);
    host.byte_io(8'hff, d);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end

  initial begin
    logic [7:0] d, d1;
    logic [7:0] c1 [2] = '{8'h7f, 8'h40};
    logic [9:0] n2t [4] = '{10'h005, 10'h019, 10'h07d, 10'h271};
    int cnt;
    {clk, nrst, fs, flock, upd, rdy, layer2, mclk, xclk, eclk} = '0;
    {set_en, clr_en, erun} = 3'b111;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    chk(n1, 8'h08);
    chk(n2, 10'h005);
    chk(n3, 6'h01);
    chk({sck_oe, ratio}, 2'b00);
    $display("test reset done");
    // control byte 1 fields
    for (int i = 0; i < 2; i++) begin
      wr_reg(DSC_ADDR_CG1, c1[i]);
      chk(sck_oe, c1[i][5]);
      chk(ratio, c1[i][6]);
      chk(n3, {1'b0, c1[i][4:0]} + 6'h01);
    end
    // control byte 2: every second divider code
    for (int i = 0; i < 4; i++) begin
      wr_reg(DSC_ADDR_CG2, {i[1:0], 4'(i * 5), 2'b00});
      chk(n1, 16'(8 * (i * 5 + 1)));
      chk(n2, n2t[i]);
    end
    rd_reg(DSC_ADDR_CG2, d);
    chk(d, 8'h00);
    chk(n2, 10'h271);
    $display("test control bytes done");
    // stopped external clock freezes the output, internal one runs
    erun = 1'b0;
    eclk = 1'b0;
    for (int m = 0; m < 2; m++) begin
      wr_reg(DSC_ADDR_CG1, m ? 8'h20 : 8'ha0);
      repeat (10) @(negedge clk);
      cnt = 0;
      d1[0] = sck;
      for (int k = 0; k < 64; k++) begin
        @(negedge clk);
        cnt += int'(sck != d1[0]);
        d1[0] = sck;
      end
      chk(cnt != 0, m[0]);
    end
    erun = 1'b1;
    $display("test clock select done");
    // status through both read paths, only judged while locked
    flock = 1'b1;
    repeat (4) @(negedge clk);
    st_rd(d);
    chk(d, 8'h02);
    pulse(fs);
    pulse(rdy);
    st_rd(d);
    chk(d, 8'hc2);
    chk({hbank, abank}, 2'b10);
    rd_reg(DSC_ADDR_STATUS, d);
    chk(d, 8'hc2);
    wr_reg(DSC_ADDR_STATUS, 8'h00);
    st_rd(d);
    chk(d, 8'hc2);
    // looped status read sees a frame start during the first byte in the second byte
    addr_phase(DSC_DOM_STATUS);
    fork
      begin
        host.byte_io(8'hff, d);
        host.byte_io(8'hff, d1);
      end
      begin
        repeat (30) @(negedge clk);
        pulse(fs);
      end
    join
    chk(d, 8'hc2);
    chk(d1, 8'h42);
    $display("test status read done");
    // valid phase held 0.8 of a 1000-cycle frame despite early update
    layer2 = 1'b1;
    pulse(fs);
    repeat (999) @(negedge clk);
    pulse(fs);
    pulse(rdy);
    repeat (10) @(negedge clk);
    pulse(upd);
    st_rd(d);
    chk(d, 8'h42);
    chk({hbank, abank}, 2'b01);
    repeat (800) @(negedge clk);
    st_rd(d);
    chk(d, 8'h02);
    $display("test valid hold done");
    // lock edges with events enabled and disabled
    flock = 1'b0;
    repeat (6) @(negedge clk);
    set_en = 1'b0;
    flock = 1'b1;
    repeat (6) @(negedge clk);
    set_en = 1'b1;
    flock = 1'b0;
    st_rd(d);
    chk(d[1], 1'b0);
    $display("test lock events done");
    test_done();
  end
endmodule

// ### verilog/dsc_l3_shifter.sv
// bit-level shifter for the three-wire host link
// pins are asynchronous to clk; link clock idles high, lsb first
module dsc_l3_shifter
  import dsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic twl_clk,
  input  wire logic twl_mode,
  input  wire logic twl_data_in,
  output logic      twl_data_out,
  output logic      twl_data_oe,
  dsc_link_if.shifter lnk
);

  logic [2:0] s1_q;  // first synchroniser stage
  logic [2:0] s2_q;  // second stage, safe to use
  logic [2:0] s3_q;  // previous value for edge detection
  logic [2:0] cnt_q; // bit position in the byte
  logic [7:0] sh_q;  // receive shift register
  logic       rise;
  logic       fall;
  logic       mchg;
  logic       drive;

  // two-stage synchronisers on link clock, mode and data
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        // link clock idles high: reset its stages high, no false rise
        s1_q[i] <= (i == 0) ? 1'b1 : 1'b0;
        s2_q[i] <= (i == 0) ? 1'b1 : 1'b0;
        s3_q[i] <= (i == 0) ? 1'b1 : 1'b0;
      end else begin
        s1_q[i] <= i == 0 ? twl_clk : (i == 1 ? twl_mode : twl_data_in);
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end
  end

  assign rise  = s2_q[0] & ~s3_q[0];
  assign fall  = ~s2_q[0] & s3_q[0];
  assign mchg  = s2_q[1] ^ s3_q[1];
  assign drive = lnk.tx_active & s2_q[1];

  // receive side: a mode change restarts byte framing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q          <= 3'h0;
      sh_q           <= 8'h00;
      lnk.rx_valid   <= 1'b0;
      lnk.rx_byte    <= 8'h00;
      lnk.rx_is_addr <= 1'b0;
      lnk.tx_req     <= 1'b0;
    end else begin
      lnk.rx_valid <= 1'b0;
      lnk.tx_req   <= 1'b0;
      if (mchg) begin
        // new phase, fresh byte; ask for data when entering a read
        cnt_q      <= 3'h0;
        lnk.tx_req <= s2_q[1];
      end else if (rise) begin
        sh_q  <= {s2_q[2], sh_q[7:1]};
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          lnk.rx_valid   <= 1'b1;
          lnk.rx_byte    <= {s2_q[2], sh_q[7:1]};
          lnk.rx_is_addr <= ~s2_q[1];
          // next byte of a looped read gets fresh contents
          lnk.tx_req     <= s2_q[1];
        end
      end
    end
  end

  // transmit side: open drain, pull low for a zero after each fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      twl_data_out <= 1'b0;
      twl_data_oe  <= 1'b0;
    end else if (!drive) begin
      twl_data_out <= 1'b0;
      twl_data_oe  <= 1'b0;
    end else if (fall) begin
      twl_data_out <= lnk.tx_byte[cnt_q];
      twl_data_oe  <= ~lnk.tx_byte[cnt_q];
    end
  end

endmodule

// ### verilog/dsc_link_if.sv
// byte-level hand-off between the three-wire shifter and the register bank
// both ends run on the same system clock
interface dsc_link_if;
  logic       rx_valid;   // one-cycle pulse, byte complete
  logic [7:0] rx_byte;    // received byte, first bit in bit 0
  logic       rx_is_addr; // byte came while mode was low
  logic       tx_req;     // pulse, a new read byte is about to start
  logic       tx_active;  // device owns the data line in this phase
  logic [7:0] tx_byte;    // byte to send, valid by the first falling edge

  modport shifter (output rx_valid, rx_byte, rx_is_addr, tx_req,
                   input  tx_active, tx_byte);
  modport regs    (input  rx_valid, rx_byte, rx_is_addr, tx_req,
                   output tx_active, tx_byte);
endinterface

// ### verilog/dsc_pkg.sv
// constants, field layouts and decode functions for the decoder status
// and clock generator register bank; assumes a 250 MHz system clock
package dsc_pkg;

  // local register addresses
  localparam logic [7:0] DSC_ADDR_CG1    = 8'h11;
  localparam logic [7:0] DSC_ADDR_CG2    = 8'h12;
  localparam logic [7:0] DSC_ADDR_STATUS = 8'h1a;

  // three-wire device address, upper six bits of the address byte
  localparam logic [5:0] DSC_DEV_ADDR = 6'h18;

  // control byte 1 field positions
  localparam int DSC_CG1_EXT_SEL = 7;
  localparam int DSC_CG1_RATIO   = 6;
  localparam int DSC_CG1_OE      = 5;
  localparam int DSC_CG1_N3_LSB  = 0;
  // control byte 2 field positions
  localparam int DSC_CG2_N2_LSB  = 6;
  localparam int DSC_CG2_N1_LSB  = 2;
  localparam int DSC_CG2_REV     = 1;
  localparam int DSC_CG2_KIND    = 0;
  // status byte field positions
  localparam int DSC_ST_TOGGLE   = 7;
  localparam int DSC_ST_VALID    = 6;
  localparam int DSC_ST_LOCK     = 1;

  // reset value of both control bytes
  localparam logic [7:0] DSC_CG_RESET = 8'h00;
  // answer for reads of write-only registers
  localparam logic [7:0] DSC_RD_NONE  = 8'h00;

  // least valid-phase hold as a fraction of the frame period
  localparam int DSC_HOLD_NUM_L1 = 4;
  localparam int DSC_HOLD_NUM_L2 = 8;
  localparam int DSC_HOLD_DEN    = 10;

  // first divider step
  localparam logic [7:0] DSC_N1_STEP = 8'h08;

  // sub-mode codes of the three-wire link
  typedef enum logic [1:0] {
    DSC_DOM_WRITE  = 2'b00,
    DSC_DOM_READ   = 2'b01,
    DSC_DOM_ADDR   = 2'b10,
    DSC_DOM_STATUS = 2'b11
  } dsc_dom_t;

  // session state, gray along idle -> selected -> ignored
  typedef enum logic [1:0] {
    DSC_SES_IDLE = 2'b00,
    DSC_SES_SEL  = 2'b01,
    DSC_SES_IGN  = 2'b11
  } dsc_ses_t;

  // first divider: 8 * (code + 1)
  function automatic logic [7:0] dsc_n1(input logic [3:0] code);
    dsc_n1 = DSC_N1_STEP * ({4'h0, code} + 8'h01);
  endfunction

  // second divider: 5, 25, 125, 625
  function automatic logic [9:0] dsc_n2(input logic [1:0] code);
    unique case (code)
      2'b00: dsc_n2 = 10'h005;
      2'b01: dsc_n2 = 10'h019;
      2'b10: dsc_n2 = 10'h07d;
      2'b11: dsc_n2 = 10'h271;
    endcase
  endfunction

  // third divider: field plus one
  function automatic logic [5:0] dsc_n3(input logic [4:0] code);
    dsc_n3 = {1'b0, code} + 6'h01;
  endfunction

endpackage

// ### verilog/dsc_regs_top.sv
// decoder status byte and clock generator control bytes behind the
// three-wire host link; decoder core signals share clk, clock pins do not
// Function
// - status byte at 1ah, toggle/valid/lock bits
// - status via status sub-mode or normal read
// - looped status reads get refreshed bytes
// - frame toggle inverts at each frame start
// - valid phase low while items update
// - valid phase high when items readable
// - valid phase holds 0.4 or 0.8 frame
// - valid phase: previous ancillary, current headers
// - lock flag follows frame border lock
// - control byte 1 at 11h, fields
// - control byte 2 at 12h, fields
// - clock select: internal or external sample clock
// - ratio bit: external 256x or 384x
// - output enable gates sample clock pin
// - detector kind: edge or xor
// - phase reversal mirrors detector characteristic
// - first divider is eight times code plus one
// - second divider 5, 25, 125, 625
// - third divider is field plus one
// - hard reset clears all control fields
// - local address precedes each register transfer
// - sub-mode 11 sends status, no address
// - lock set and clear events, separately enabled
module dsc_regs_top
  import dsc_pkg::*;
#(
  parameter int PW = 20 // frame period counter width
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic twl_clk,
  input  wire logic twl_mode,
  input  wire logic twl_data_in,
  output logic      twl_data_out,
  output logic      twl_data_oe,
  input  wire logic frame_start,
  input  wire logic frame_lock,
  input  wire logic items_update,
  input  wire logic items_ready,
  input  wire logic layer2,
  input  wire logic lock_set_event_en,
  input  wire logic lock_clr_event_en,
  output logic      lock_set_event,
  output logic      lock_clr_event,
  output logic      anc_bank,
  output logic      hdr_bank,
  input  wire logic master_clock_in,
  input  wire logic aux_crystal_clock_in,
  input  wire logic ext_sample_clock_in,
  output logic      sample_clock_out,
  output logic      sample_clock_oe,
  output logic      external_ratio_select,
  output logic      phase_up,
  output logic      phase_dn,
  output logic [7:0] first_divider,
  output logic [9:0] second_divider,
  output logic [5:0] third_divider
);

  dsc_link_if lnk ();

  dsc_ses_t         ses_q;        // session state
  dsc_dom_t         dom_q;        // current sub-mode
  logic [7:0]       loc_q;        // local register address
  logic             loc_ok_q;     // an address has been given
  logic [7:0]       cg1_q;        // control byte 1
  logic [7:0]       cg2_q;        // control byte 2
  logic             frame_toggle_q;
  logic             data_valid_phase_q;
  logic             frame_lock_flag_q;
  logic [PW-1:0]    per_cnt_q;    // cycles since last frame start
  logic [PW-1:0]    per_q;        // last measured frame period
  logic [PW-1:0]    hold_q;       // cycles valid has been high
  logic             clr_pend_q;   // update seen before hold ran out
  logic [PW+3:0]    hold_lim;     // least hold in cycles
  logic [2:0]       cs1_q;        // clock pin synchroniser stage 1
  logic [2:0]       cs2_q;        // stage 2
  logic [2:0]       cs3_q;        // previous for edges
  logic [2:0]       cedge;        // rising edges of clock pins
  logic [9:0]       dlim [3];     // divide values per divider
  logic [9:0]       dcnt_q [3];   // edge counters
  logic [2:0]       tgl_q;        // divided outputs
  logic [2:0]       tgl_p_q;      // previous divided outputs
  logic             pd_up_q;      // edge detector state, up
  logic             pd_dn_q;      // edge detector state, down

  dsc_l3_shifter u_shift (
    .clk         (clk),
    .nrst        (nrst),
    .twl_clk     (twl_clk),
    .twl_mode    (twl_mode),
    .twl_data_in (twl_data_in),
    .twl_data_out(twl_data_out),
    .twl_data_oe (twl_data_oe),
    .lnk         (lnk.shifter)
  );

  // status byte, undefined bits read zero
  function automatic logic [7:0] st_byte(input logic t, input logic v,
                                         input logic l);
    st_byte = 8'h00;
    st_byte[DSC_ST_TOGGLE] = t;
    st_byte[DSC_ST_VALID]  = v;
    st_byte[DSC_ST_LOCK]   = l;
  endfunction

  // frame counter and item banks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_toggle_q <= 1'b0;
      hdr_bank       <= 1'b0;
      anc_bank       <= 1'b1;
    end else if (frame_start) begin
      frame_toggle_q <= ~frame_toggle_q;
      // headers of this frame, ancillary data of the one before
      hdr_bank       <= ~frame_toggle_q;
      anc_bank       <= frame_toggle_q;
    end
  end

  // lock flag and its edge events
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_lock_flag_q <= 1'b0;
      lock_set_event    <= 1'b0;
      lock_clr_event    <= 1'b0;
    end else begin
      frame_lock_flag_q <= frame_lock;
      lock_set_event <= lock_set_event_en & frame_lock &
                        ~frame_lock_flag_q;
      lock_clr_event <= lock_clr_event_en & ~frame_lock &
                        frame_lock_flag_q;
    end
  end

  // frame period measurement, saturates when frames stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_q <= '0;
      per_q     <= '0;
    end else if (frame_start) begin
      per_q     <= per_cnt_q;
      per_cnt_q <= '0;
    end else if (per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // least hold; the first frame after reset has no period yet
  assign hold_lim = ({4'h0, per_q} *
                     (layer2 ? (PW+4)'(DSC_HOLD_NUM_L2)
                             : (PW+4)'(DSC_HOLD_NUM_L1)))
                    / (PW+4)'(DSC_HOLD_DEN);

  // valid phase: set when items are ready, cleared by an update start
  // no earlier than the least hold; a too-early update is deferred
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_valid_phase_q <= 1'b0;
      hold_q             <= '0;
      clr_pend_q         <= 1'b0;
    end else if (items_ready) begin
      data_valid_phase_q <= 1'b1;
      hold_q             <= '0;
      clr_pend_q         <= 1'b0;
    end else if (data_valid_phase_q) begin
      if (hold_q != '1) begin
        hold_q <= hold_q + 1'b1;
      end
      if (items_update || clr_pend_q) begin
        if ({4'h0, hold_q} >= hold_lim) begin
          data_valid_phase_q <= 1'b0;
          clr_pend_q         <= 1'b0;
        end else begin
          clr_pend_q <= 1'b1;
        end
      end
    end
  end

  // link session: device address, sub-mode, local address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ses_q    <= DSC_SES_IDLE;
      dom_q    <= DSC_DOM_WRITE;
      loc_q    <= 8'h00;
      loc_ok_q <= 1'b0;
    end else if (lnk.rx_valid && lnk.rx_is_addr) begin
      if (lnk.rx_byte[7:2] == DSC_DEV_ADDR) begin
        ses_q <= DSC_SES_SEL;
        dom_q <= dsc_dom_t'(lnk.rx_byte[1:0]);
      end else begin
        ses_q <= DSC_SES_IGN;
      end
    end else if (lnk.rx_valid && ses_q == DSC_SES_SEL &&
                 dom_q == DSC_DOM_ADDR) begin
      loc_q    <= lnk.rx_byte;
      loc_ok_q <= 1'b1;
    end
  end

  // control byte writes; status address and others ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cg1_q <= DSC_CG_RESET;
      cg2_q <= DSC_CG_RESET;
    end else if (lnk.rx_valid && !lnk.rx_is_addr &&
                 ses_q == DSC_SES_SEL && dom_q == DSC_DOM_WRITE &&
                 loc_ok_q) begin
      unique case (loc_q)
        DSC_ADDR_CG1: cg1_q <= lnk.rx_byte;
        DSC_ADDR_CG2: cg2_q <= lnk.rx_byte;
        default:      ;
      endcase
    end
  end

  // read path: snapshot taken at each byte start of a read phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lnk.tx_active <= 1'b0;
      lnk.tx_byte   <= 8'h00;
    end else begin
      unique case (ses_q)
        DSC_SES_SEL:
          lnk.tx_active <= dom_q == DSC_DOM_STATUS ||
                           (dom_q == DSC_DOM_READ && loc_ok_q);
        DSC_SES_IDLE, DSC_SES_IGN: lnk.tx_active <= 1'b0;
        default: lnk.tx_active <= 1'b0;
      endcase
      if (lnk.tx_req) begin
        if (dom_q == DSC_DOM_STATUS || loc_q == DSC_ADDR_STATUS) begin
          lnk.tx_byte <= st_byte(frame_toggle_q,
                                 data_valid_phase_q, frame_lock_flag_q);
        end else begin
          // write-only registers answer zero, contents untouched
          lnk.tx_byte <= DSC_RD_NONE;
        end
      end
    end
  end

  // decoded divider values for the clock generator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_divider         <= dsc_n1(4'h0);
      second_divider        <= dsc_n2(2'b00);
      third_divider         <= dsc_n3(5'h00);
      external_ratio_select <= 1'b0;
    end else begin
      first_divider  <= dsc_n1(cg2_q[DSC_CG2_N1_LSB +: 4]);
      second_divider <= dsc_n2(cg2_q[DSC_CG2_N2_LSB +: 2]);
      third_divider  <= dsc_n3(cg1_q[DSC_CG1_N3_LSB +: 5]);
      // sample clock ratio handed to the external clock path
      external_ratio_select <= cg1_q[DSC_CG1_RATIO];
    end
  end

  // clock pin synchronisers: master, aux crystal, external sample clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs1_q <= 3'h0;
      cs2_q <= 3'h0;
      cs3_q <= 3'h0;
    end else begin
      cs1_q <= {ext_sample_clock_in, aux_crystal_clock_in,
                master_clock_in};
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
    end
  end
  assign cedge = cs2_q & ~cs3_q;

  // divider 0: master by third, 1: master by first, 2: aux by second
  assign dlim[0] = {4'h0, third_divider};
  assign dlim[1] = {2'b00, first_divider};
  assign dlim[2] = second_divider;

  for (genvar i = 0; i < 3; i++) begin : g_div
    // edge counter toggling its output every dlim edges
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        dcnt_q[i]  <= 10'h000;
        tgl_q[i]   <= 1'b0;
        tgl_p_q[i] <= 1'b0;
      end else begin
        tgl_p_q[i] <= tgl_q[i];
        if (cedge[i == 2 ? 1 : 0]) begin
          if (dcnt_q[i] >= dlim[i] - 10'h001) begin
            dcnt_q[i] <= 10'h000;
            tgl_q[i]  <= ~tgl_q[i];
          end else begin
            dcnt_q[i] <= dcnt_q[i] + 10'h001;
          end
        end
      end
    end
  end

  // sample clock source and pin enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_clock_out <= 1'b0;
      sample_clock_oe  <= 1'b0;
    end else begin
      sample_clock_out <= cg1_q[DSC_CG1_EXT_SEL] ? cs2_q[2]
                                                 : tgl_q[0];
      sample_clock_oe  <= cg1_q[DSC_CG1_OE];
    end
  end

  // edge detector state: ref edge raises up or clears a pending down, feedback edge raises down or clears a pending up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_up_q <= 1'b0;
      pd_dn_q <= 1'b0;
    end else begin
      if (tgl_q[2] & ~tgl_p_q[2]) begin
        pd_up_q <= ~pd_dn_q;
        pd_dn_q <= 1'b0;
      end else if (tgl_q[1] & ~tgl_p_q[1]) begin
        pd_dn_q <= ~pd_up_q;
        pd_up_q <= 1'b0;
      end
    end
  end

  // detector output: kind selects edge or xor, reversal swaps sense
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_up <= 1'b0;
      phase_dn <= 1'b0;
    end else if (cg2_q[DSC_CG2_KIND]) begin
      phase_up <= (tgl_q[2] ^ tgl_q[1]) &
                  (cg2_q[DSC_CG2_REV] ? tgl_q[1] : tgl_q[2]);
      phase_dn <= (tgl_q[2] ^ tgl_q[1]) &
                  (cg2_q[DSC_CG2_REV] ? tgl_q[2] : tgl_q[1]);
    end else begin
      phase_up <= cg2_q[DSC_CG2_REV] ? pd_dn_q : pd_up_q;
      phase_dn <= cg2_q[DSC_CG2_REV] ? pd_up_q : pd_dn_q;
    end
  end

endmodule
